// ### design/epo_map.svh
// Address map, field positions and timing constants of the energy pulse output block
`ifndef EPO_MAP_SVH
`define EPO_MAP_SVH
`define EPO_CLK_KHZ 40000
`define EPO_OSC_HZ 450000
`define EPO_OSC_DIV ((`EPO_CLK_KHZ * 1000) / `EPO_OSC_HZ)
`define EPO_PWR_W 24
`define EPO_ACC_W 48
`define EPO_BASE_SHIFT 19
`define EPO_K_INV 5
`define EPO_MIN_RATE_PPB 24400
`define EPO_LR_WIDTH_MS 240
`define EPO_LR_SHORT_MS 240
`define EPO_CF_WIDTH_MS 90
`define EPO_CF_SHORT_MS 180
`define EPO_HF_WIDTH_US 35
`define EPO_HF_WIDTH_CYC ((`EPO_HF_WIDTH_US * `EPO_CLK_KHZ) / 1000)
`define EPO_HF_LOG2 4'hB
`define EPO_ADDR_STATUS 4'h0
`define EPO_ADDR_MASK 4'h4
`define EPO_ADDR_STATE 4'h8
`define EPO_EV_CF 0
`define EPO_EV_LR 1
`define EPO_EV_POL 2
`define EPO_EV_W 3
`endif

// ### design/epo_pkg.sv
// Types of the energy pulse output block
`include "epo_map.svh"
package epo_pkg;
   typedef struct packed {
      logic calib_scale_select;
      logic freq_select_hi;
      logic freq_select_lo;
   } epo_sel_t;
   typedef struct packed {
      logic [3:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } epo_bus_t;
   typedef struct packed {
      logic [`EPO_ACC_W-1:0] acc_lr;
      logic [`EPO_ACC_W-1:0] acc_cf;
      logic [31:0] per_lr;
      logic [31:0] per_cf;
      logic [31:0] wid_lr;
      logic [31:0] wid_cf;
      logic [7:0] pre;
      logic sel_b;
      logic lr_on_b;
      logic lr_a_n;
      logic lr_b_n;
      logic cf;
      logic neg;
      logic cf_evt;
      logic lr_evt;
      logic [`EPO_EV_W-1:0] status;
      logic [`EPO_EV_W-1:0] mask;
      logic [31:0] rdata;
      logic irq;
   } epo_state_t;
endpackage : epo_pkg

// ### design/epo_pulse_out.sv
// Energy pulse output logic: low-rate pair, calibration pulse, polarity flag
//
// Contract
// - Calibration pulse rate is a selectable multiple of low-rate rate, up to 2048.
// - Scale select high: multiples 128, 64, 32, 16 for codes 00..11.
// - Scale select low: 64, 32, 16 for 00..10; code 11 is 2048 fast mode.
// - Calibration train accumulates the same power over a far shorter interval.
// - Low-rate pulses alternate between the two outputs; base sets peak rate.
// - Low-rate period under 240 ms gives a width of half the period.
// - Normal calibration pulse is active high, 90 ms, rate proportional to power.
// - Calibration period under 180 ms gives a width of half the period.
// - Fast mode fixes the calibration pulse width at 35 us.
// - Minimum output rate is 0.00244 percent of the selected base frequency.
// - Load below the minimum rate suppresses all three pulse outputs.
// - Polarity flag high for negative power, low for positive power.
// - Polarity flag changes only when a calibration pulse is issued.
// - Both low-rate outputs are active low.
// - Base frequency is oscillator over 2^19, 2^18, 2^17 or 2^16.
`timescale 1ns/100ps
module epo_pulse_out #(
   parameter int LR_WIDTH_CYC = `EPO_LR_WIDTH_MS * `EPO_CLK_KHZ,
   parameter int LR_SHORT_CYC = `EPO_LR_SHORT_MS * `EPO_CLK_KHZ,
   parameter int CF_WIDTH_CYC = `EPO_CF_WIDTH_MS * `EPO_CLK_KHZ,
   parameter int CF_SHORT_CYC = `EPO_CF_SHORT_MS * `EPO_CLK_KHZ
) (
   input wire logic i_core_clk, // 40 MHz core clock
   input wire logic i_resetn, // Async reset, active low
   input wire logic signed [`EPO_PWR_W-1:0] i_power, // Filtered real power
   input wire epo_pkg::epo_sel_t i_sel, // Strapped selection inputs
   input wire epo_pkg::epo_bus_t i_bus, // Register port request
   output logic [31:0] o_rdata, // Read data, cycle after read
   output logic o_low_rate_pulse_a_n, // Low-rate output A
   output logic o_low_rate_pulse_b_n, // Low-rate output B
   output logic o_calibration_pulse_out, // Calibration pulse
   output logic o_negative_power_flag, // Polarity flag
   output logic o_irq // Interrupt, level
);
   // ************************************************
   // Constants
   // ************************************************
   localparam longint FS = 64'd1 << (`EPO_PWR_W - 1);
   localparam logic [`EPO_ACC_W-1:0] LR_BASE =
      `EPO_ACC_W'((FS * `EPO_K_INV) << `EPO_BASE_SHIFT);
   localparam logic [`EPO_PWR_W-1:0] NOLOAD_PWR =
      `EPO_PWR_W'((FS * `EPO_K_INV * `EPO_MIN_RATE_PPB) / 64'd1000000000);
   localparam logic [7:0] OSC_LAST = 8'(`EPO_OSC_DIV - 1);
   localparam logic [31:0] HF_W = 32'(`EPO_HF_WIDTH_CYC);

   if (LR_WIDTH_CYC < 1 || CF_WIDTH_CYC < 1 || LR_SHORT_CYC < 2 || CF_SHORT_CYC < 2) begin : g_bad
      $error("epo_pulse_out: pulse timing parameters too small");
   end

   // ************************************************
   // Selection decode
   // ************************************************
   // Lower base frequency means a larger threshold
   function automatic logic [`EPO_ACC_W-1:0] lr_thr(input logic [1:0] code);
      lr_thr = LR_BASE >> code;
   endfunction : lr_thr

   function automatic logic [3:0] cf_log2(input epo_pkg::epo_sel_t sel);
      logic [1:0] code;
      code = {sel.freq_select_hi, sel.freq_select_lo};
      if (sel.calib_scale_select) begin
         cf_log2 = 4'h7 - {2'h0, code};
      end else if (code == 2'h3) begin
         cf_log2 = `EPO_HF_LOG2;
      end else begin
         cf_log2 = 4'h6 - {2'h0, code};
      end
   endfunction : cf_log2

   function automatic logic [31:0] width(input logic [31:0] per, input int short_c,
                                         input int full_c);
      logic [31:0] per_n;
      logic [31:0] half;
      // Counter holds one less than the rise-to-rise period; saturated means slow
      per_n = (per == 32'hFFFFFFFF) ? per : per + 32'h1;
      half = per_n >> 1;
      if (per_n < 32'(short_c)) begin
         width = (half == 32'h0) ? 32'h1 : half;
      end else begin
         width = 32'(full_c);
      end
   endfunction : width

   // ************************************************
   // State
   // ************************************************
   epo_pkg::epo_state_t s_reg;
   epo_pkg::epo_state_t s_next;
   logic [1:0] code;
   logic hf;
   logic tick;
   logic noload;
   logic [`EPO_PWR_W-1:0] mag;
   logic [`EPO_ACC_W-1:0] t_lr;
   logic [`EPO_ACC_W-1:0] t_cf;
   logic [`EPO_ACC_W-1:0] sum_lr;
   logic [`EPO_ACC_W-1:0] sum_cf;
   logic [`EPO_EV_W-1:0] ev;
   logic [`EPO_EV_W-1:0] clr;

   assign code = {i_sel.freq_select_hi, i_sel.freq_select_lo};
   assign hf = !i_sel.calib_scale_select && code == 2'h3;
   assign tick = s_reg.pre == OSC_LAST;
   assign mag = i_power[`EPO_PWR_W-1] ? `EPO_PWR_W'(-i_power) : `EPO_PWR_W'(i_power);
   assign noload = mag < NOLOAD_PWR;
   assign t_lr = lr_thr(code);
   assign t_cf = t_lr >> cf_log2(i_sel);
   assign sum_lr = s_reg.acc_lr + `EPO_ACC_W'(mag);
   assign sum_cf = s_reg.acc_cf + `EPO_ACC_W'(mag);

   always_comb begin
      s_next = s_reg;
      ev = '0;
      clr = '0;
      s_next.cf_evt = 1'b0;
      s_next.lr_evt = 1'b0;
      s_next.rdata = 32'h0;
      s_next.pre = tick ? 8'h0 : s_reg.pre + 8'h1;
      if (s_reg.per_lr != 32'hFFFFFFFF) begin
         s_next.per_lr = s_reg.per_lr + 32'h1;
      end
      if (s_reg.per_cf != 32'hFFFFFFFF) begin
         s_next.per_cf = s_reg.per_cf + 32'h1;
      end
      s_next.wid_lr = (s_reg.wid_lr != 32'h0) ? s_reg.wid_lr - 32'h1 : 32'h0;
      s_next.wid_cf = (s_reg.wid_cf != 32'h0) ? s_reg.wid_cf - 32'h1 : 32'h0;
      // Below the creep floor the accumulators hold; nothing is issued
      if (tick && !noload) begin
         if (sum_lr >= t_lr) begin
            s_next.acc_lr = sum_lr - t_lr;
            s_next.lr_evt = 1'b1;
         end else begin
            s_next.acc_lr = sum_lr;
         end
         // Smaller threshold, so far less averaging of ripple
         if (sum_cf >= t_cf) begin
            s_next.acc_cf = sum_cf - t_cf;
            s_next.cf_evt = 1'b1;
         end else begin
            s_next.acc_cf = sum_cf;
         end
      end
      if (s_next.lr_evt) begin
         s_next.wid_lr = width(s_reg.per_lr, LR_SHORT_CYC, LR_WIDTH_CYC);
         s_next.per_lr = 32'h0;
         s_next.lr_on_b = s_reg.sel_b;
         s_next.sel_b = !s_reg.sel_b;
         ev[`EPO_EV_LR] = 1'b1;
      end
      if (s_next.cf_evt) begin
         if (hf) begin
            s_next.wid_cf = HF_W;
         end else begin
            s_next.wid_cf = width(s_reg.per_cf, CF_SHORT_CYC, CF_WIDTH_CYC);
         end
         s_next.per_cf = 32'h0;
         s_next.neg = i_power[`EPO_PWR_W-1];
         ev[`EPO_EV_CF] = 1'b1;
         ev[`EPO_EV_POL] = s_next.neg != s_reg.neg;
      end
      s_next.lr_a_n = !(s_next.wid_lr != 32'h0 && !s_next.lr_on_b);
      s_next.lr_b_n = !(s_next.wid_lr != 32'h0 && s_next.lr_on_b);
      s_next.cf = s_next.wid_cf != 32'h0;
      // Register port; a new event beats a clear in the same cycle
      if (i_bus.wr && i_bus.addr == `EPO_ADDR_STATUS) begin
         clr = i_bus.wdata[`EPO_EV_W-1:0];
      end
      if (i_bus.wr && i_bus.addr == `EPO_ADDR_MASK) begin
         s_next.mask = i_bus.wdata[`EPO_EV_W-1:0];
      end
      s_next.status = (s_reg.status & ~clr) | ev;
      if (i_bus.rd) begin
         case (i_bus.addr)
            `EPO_ADDR_STATUS: s_next.rdata = {29'h0, s_reg.status};
            `EPO_ADDR_MASK: s_next.rdata = {29'h0, s_reg.mask};
            `EPO_ADDR_STATE: s_next.rdata = {24'h0, hf, noload, s_reg.lr_on_b,
                                            s_reg.neg, 1'b0, i_sel};
            default: s_next.rdata = 32'h0;
         endcase
      end
      s_next.irq = |(s_next.status & s_next.mask);
   end

   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         s_reg <= '0;
         s_reg.lr_a_n <= 1'b1;
         s_reg.lr_b_n <= 1'b1;
         s_reg.per_lr <= 32'hFFFFFFFF;
         s_reg.per_cf <= 32'hFFFFFFFF;
      end else begin
         s_reg <= s_next;
      end
   end

   assign o_rdata = s_reg.rdata;
   assign o_low_rate_pulse_a_n = s_reg.lr_a_n;
   assign o_low_rate_pulse_b_n = s_reg.lr_b_n;
   assign o_calibration_pulse_out = s_reg.cf;
   assign o_negative_power_flag = s_reg.neg;
   assign o_irq = s_reg.irq;

   // ************************************************
   // Checks
   // ************************************************
   logic [31:0] cf_hi_cnt;
   logic [31:0] cf_gap_cnt;
   logic [31:0] cf_per_l;
   logic [31:0] lr_lo_cnt;
   logic cf_hf;
   logic last_b;
   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         cf_hi_cnt <= 32'h0;
         cf_gap_cnt <= 32'hFFFFFFFF;
         cf_per_l <= 32'hFFFFFFFF;
         lr_lo_cnt <= 32'h0;
         cf_hf <= 1'b0;
         last_b <= 1'b1;
      end else begin
         cf_hi_cnt <= s_reg.cf_evt ? 32'h1 : (s_reg.cf ? cf_hi_cnt + 32'h1 : 32'h0);
         lr_lo_cnt <= s_reg.lr_evt ? 32'h1 :
            ((s_reg.lr_a_n && s_reg.lr_b_n) ? 32'h0 : lr_lo_cnt + 32'h1);
         // Rise-to-rise distance, saturating so the first pulse counts as slow
         if (s_reg.cf_evt) begin
            cf_gap_cnt <= 32'h1;
            cf_per_l <= cf_gap_cnt;
         end else if (cf_gap_cnt != 32'hFFFFFFFF) begin
            cf_gap_cnt <= cf_gap_cnt + 32'h1;
         end
         // Mode at launch decides which width bound applies
         if (s_next.cf_evt) begin
            cf_hf <= hf;
         end
         if (s_reg.lr_evt) begin
            last_b <= s_reg.lr_on_b;
         end
      end
   end

   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_resetn);

   // ************************************************
   // Properties
   // ************************************************

   property p_hf_width;
      $fell(s_reg.cf) && hf && $past(hf) |-> cf_hi_cnt == HF_W;
   endproperty
   a_hf_width: assert property (p_hf_width) else $error("fast pulse width wrong");
   property p_cf_max;
      cf_hi_cnt <= (cf_hf ? HF_W : 32'(CF_WIDTH_CYC));
   endproperty
   a_cf_max: assert property (p_cf_max) else $error("calib pulse too long");
   property p_lr_excl;
      !(!o_low_rate_pulse_a_n && !o_low_rate_pulse_b_n);
   endproperty
   a_lr_excl: assert property (p_lr_excl) else $error("both low-rate active");
   property p_alt;
      s_reg.lr_evt |-> s_reg.lr_on_b != last_b;
   endproperty
   a_alt: assert property (p_alt) else $error("low-rate did not alternate");
   property p_flag_when;
      $changed(o_negative_power_flag) |-> s_reg.cf_evt;
   endproperty
   a_flag_when: assert property (p_flag_when) else $error("flag moved off pulse");
   property p_flag_val;
      s_reg.cf_evt |-> o_negative_power_flag == $past(i_power[`EPO_PWR_W-1]);
   endproperty
   a_flag_val: assert property (p_flag_val) else $error("flag polarity wrong");
   property p_noload;
      noload |=> !s_reg.cf_evt && !s_reg.lr_evt;
   endproperty
   a_noload: assert property (p_noload) else $error("pulse below no-load floor");
   property p_cf_rise;
      $rose(s_reg.cf) |-> s_reg.cf_evt ##1 s_reg.cf;
   endproperty
   a_cf_rise: assert property (p_cf_rise) else $error("calib pulse without event");
   property p_irq;
      o_irq == |(s_reg.status & s_reg.mask);
   endproperty
   a_irq: assert property (p_irq) else $error("irq disagrees with status");
   // A fast pulse period is measured by the same counter, so exclude it
   property p_cf_half;
      $fell(s_reg.cf) && !cf_hf && cf_per_l < 32'(CF_SHORT_CYC)
         |-> cf_hi_cnt == (cf_per_l >> 1);
   endproperty
   a_cf_half: assert property (p_cf_half) else $error("calib half width wrong");
   property p_lr_max;
      lr_lo_cnt <= 32'(LR_WIDTH_CYC);
   endproperty
   a_lr_max: assert property (p_lr_max) else $error("low-rate pulse too long");
   property p_evt_tick;
      (s_reg.cf_evt || s_reg.lr_evt) |-> $past(tick);
   endproperty
   a_evt_tick: assert property (p_evt_tick) else $error("event off a tick");
   property p_lr_one;
      s_reg.lr_evt |-> o_low_rate_pulse_a_n != o_low_rate_pulse_b_n;
   endproperty
   a_lr_one: assert property (p_lr_one) else $error("low-rate pulse not on one output");

   c_hf: cover property (s_reg.cf_evt && hf);
   c_lr_a: cover property ($fell(o_low_rate_pulse_a_n));
   c_lr_b: cover property ($fell(o_low_rate_pulse_b_n));
   c_pol: cover property ($changed(o_negative_power_flag));
   c_irq: cover property ($rose(o_irq));
endmodule : epo_pulse_out

// ### verif/epo_pulse_counter.sv
// Pulse counter model watching the low-rate and calibration outputs
`timescale 1ns/100ps
module epo_pulse_counter (
   input wire logic i_core_clk, // Core clock
   input wire logic i_resetn, // Reset, active low
   input wire logic i_lr_a_n, // Low-rate output A
   input wire logic i_lr_b_n, // Low-rate output B
   input wire logic i_cf, // Calibration pulse
   output logic [31:0] o_cf_count, // Calibration pulses seen
   output logic [31:0] o_lr_count, // Low-rate pulses seen
   output logic [31:0] o_cf_width, // Last calibration width
   output logic [31:0] o_cf_period // Last rise to rise time
);
   // ***************************
   // Edge counting
   // ***************************
   logic [31:0] cyc_reg;
   logic [31:0] run_reg;
   logic [31:0] rise_reg;
   logic cf_d_reg;
   logic lr_d_reg;
   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         cyc_reg <= 32'h0;
         run_reg <= 32'h0;
         rise_reg <= 32'h0;
         cf_d_reg <= 1'b0;
         lr_d_reg <= 1'b1;
         o_cf_count <= 32'h0;
         o_lr_count <= 32'h0;
         o_cf_width <= 32'h0;
         o_cf_period <= 32'h0;
      end else begin
         cyc_reg <= cyc_reg + 32'h1;
         cf_d_reg <= i_cf;
         lr_d_reg <= i_lr_a_n & i_lr_b_n;
         // Width counts the edges that saw the pulse high
         run_reg <= i_cf ? run_reg + 32'h1 : 32'h0;
         if (i_cf && !cf_d_reg) begin
            o_cf_count <= o_cf_count + 32'h1;
            o_cf_period <= cyc_reg - rise_reg;
            rise_reg <= cyc_reg;
         end
         if (!i_cf && cf_d_reg) begin
            o_cf_width <= run_reg;
         end
         if (!(i_lr_a_n & i_lr_b_n) && lr_d_reg) begin
            o_lr_count <= o_lr_count + 32'h1;
         end
      end
   end
endmodule : epo_pulse_counter

// ### verif/test_epo_pulse_out.sv
// Self-checking testbench of the energy pulse output block
`timescale 1ns/100ps
`include "epo_map.svh"
module test_epo_pulse_out;
   logic i_core_clk = 1'b0;
   logic i_resetn = 1'b0;
   logic signed [`EPO_PWR_W-1:0] i_power = 24'h0;
   epo_pkg::epo_sel_t i_sel = 3'h0;
   epo_pkg::epo_bus_t i_bus = '0;
   logic [31:0] o_rdata;
   logic o_low_rate_pulse_a_n;
   logic o_low_rate_pulse_b_n;
   logic o_calibration_pulse_out;
   logic o_negative_power_flag;
   logic o_irq;
   logic [31:0] cf_count;
   logic [31:0] lr_count;
   logic [31:0] cf_width;
   logic [31:0] cf_period;
   logic [31:0] rd;
   logic [31:0] snap;
   int num_errors = 0;
   int n_tests = 0;
   always #12.5 i_core_clk = ~i_core_clk;
   epo_pulse_out #(.LR_WIDTH_CYC(200), .LR_SHORT_CYC(200), .CF_WIDTH_CYC(100),
      .CF_SHORT_CYC(200)) dut (.i_core_clk(i_core_clk), .i_resetn(i_resetn),
      .i_power(i_power), .i_sel(i_sel), .i_bus(i_bus), .o_rdata(o_rdata),
      .o_low_rate_pulse_a_n(o_low_rate_pulse_a_n), .o_low_rate_pulse_b_n(o_low_rate_pulse_b_n),
      .o_calibration_pulse_out(o_calibration_pulse_out),
      .o_negative_power_flag(o_negative_power_flag), .o_irq(o_irq));
   epo_pulse_counter counter (.i_core_clk(i_core_clk), .i_resetn(i_resetn),
      .i_lr_a_n(o_low_rate_pulse_a_n), .i_lr_b_n(o_low_rate_pulse_b_n),
      .i_cf(o_calibration_pulse_out), .o_cf_count(cf_count), .o_lr_count(lr_count),
      .o_cf_width(cf_width), .o_cf_period(cf_period));
   // ***************************
   // Tasks
   // ***************************
   task automatic finish_test;
      $display("errors %0d in %0d checks", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : finish_test
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wr_reg(input logic [3:0] addr, input logic [31:0] data);
      @(posedge i_core_clk);
      i_bus <= '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
      @(posedge i_core_clk);
      i_bus.wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [3:0] addr, output logic [31:0] data);
      @(posedge i_core_clk);
      i_bus <= '{addr: addr, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge i_core_clk);
      i_bus.rd <= 1'b0;
      #1;
      data = o_rdata;
   endtask : rd_reg
   // Bounded wait, a missing pulse ends the run
   task automatic wait_cf(input int lim);
      logic [31:0] start;
      start = cf_count;
      for (int i = 0; i < lim && cf_count == start; i++) begin
         @(posedge i_core_clk);
         #1;
      end
      if (cf_count == start) begin
         num_errors++;
         finish_test();
      end
   endtask : wait_cf
   // ***************************
   // Sequence
   // ***************************
   initial begin
      repeat (4) @(posedge i_core_clk);
      i_resetn <= 1'b1;
      @(posedge i_core_clk);
      #1;
      check(32'(o_low_rate_pulse_a_n), 32'h1);
      check(32'(o_low_rate_pulse_b_n), 32'h1);
      check(32'(o_calibration_pulse_out), 32'h0);
      check(32'(o_irq), 32'h0);
      rd_reg(`EPO_ADDR_MASK, rd);
      check(rd, 32'h0);
      for (int k = 0; k < 8; k++) begin
         @(posedge i_core_clk);
         i_sel <= epo_pkg::epo_sel_t'(k[2:0]);
         rd_reg(`EPO_ADDR_STATE, rd);
         check(rd, 32'(k) | 32'h40 | ((k == 3) ? 32'h80 : 32'h0));
      end
      wr_reg(`EPO_ADDR_STATE, 32'hFFFFFFFF);
      rd_reg(`EPO_ADDR_STATE, rd);
      check(rd, 32'h47);
      rd_reg(4'hC, rd);
      check(rd, 32'h0);
      // Fast mode at full power keeps the run short
      @(posedge i_core_clk);
      i_sel <= 3'h3;
      i_power <= 24'h7FFFFF;
      wait_cf(20000);
      check(32'(o_negative_power_flag), 32'h0);
      rd_reg(`EPO_ADDR_STATUS, rd);
      check(rd, 32'h1);
      check(32'(o_irq), 32'h0);
      for (int i = 0; i < 2000 && o_calibration_pulse_out !== 1'b0; i++) begin
         @(posedge i_core_clk);
         #1;
      end
      if (o_calibration_pulse_out !== 1'b0) begin
         num_errors++;
         finish_test();
      end
      @(posedge i_core_clk);
      #1;
      check(cf_width, `EPO_HF_WIDTH_CYC);
      @(posedge i_core_clk);
      i_power <= 24'h800001;
      repeat (10) @(posedge i_core_clk);
      #1;
      check(32'(o_negative_power_flag), 32'h0);
      wait_cf(20000);
      check(32'(o_negative_power_flag), 32'h1);
      check(32'(cf_period >= 32'd14000 && cf_period <= 32'd14300), 32'h1);
      check(lr_count, 32'h0);
      rd_reg(`EPO_ADDR_STATUS, rd);
      check(rd, 32'h5);
      wr_reg(`EPO_ADDR_MASK, 32'h5);
      rd_reg(`EPO_ADDR_MASK, rd);
      check(rd, 32'h5);
      check(32'(o_irq), 32'h1);
      wr_reg(`EPO_ADDR_STATUS, 32'h7);
      rd_reg(`EPO_ADDR_STATUS, rd);
      check(rd, 32'h0);
      check(32'(o_irq), 32'h0);
      // Below the floor no train may advance
      @(posedge i_core_clk);
      i_power <= 24'h0003E8;
      snap = cf_count;
      repeat (30000) @(posedge i_core_clk);
      #1;
      check(cf_count, snap);
      rd_reg(`EPO_ADDR_STATE, rd);
      check(rd, 32'hD3);
      finish_test();
   end
endmodule : test_epo_pulse_out
